// File: inc/cu_timer_pkg.sv
package cu_timer_pkg;

   // -----------------------------------------------------------------
   // bus geometry
   // -----------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // -----------------------------------------------------------------
   // register indices; byte address is four times the index
   // -----------------------------------------------------------------
   localparam logic [15:0] IDX_PRESCALER_LOW = 16'h631B;
   localparam logic [15:0] IDX_RELOAD_HIGH = 16'h631C;
   localparam logic [15:0] IDX_RELOAD_LOW = 16'h631D;
   localparam logic [15:0] IDX_COUNT_HIGH = 16'h631E;
   localparam logic [15:0] IDX_COUNT_LOW = 16'h631F;
   localparam logic [15:0] IDX_TIMER_MODE = 16'h6330;
   localparam logic [15:0] IDX_TIMER_CTRL = 16'h6331;

   // -----------------------------------------------------------------
   // field layout and reset values
   // -----------------------------------------------------------------
   localparam int MODE_PRESC_LSB = 0;     // prescaler_upper_nibble [3:0]
   localparam int MODE_AUTO_BIT = 4;      // auto_reload_on_zero
   localparam int MODE_GATE_LSB = 5;      // gating_source_select [6:5]
   localparam int CTRL_START_BIT = 0;     // write 1: start event
   localparam int CTRL_STOP_BIT = 1;      // write 1: stop now
   localparam int CTRL_RUN_BIT = 2;       // read: running
   localparam int CTRL_FLAG_BIT = 3;      // read: timeout_flag, write 1 clears
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [11:0] PRESC_ONE = 12'h001;

   // -----------------------------------------------------------------
   // gating source codes
   // -----------------------------------------------------------------
   localparam logic [1:0] GATE_NONE = 2'h0;
   localparam logic [1:0] GATE_SIGNAL_INPUT = 2'h1;
   localparam logic [1:0] GATE_FIRST_AUX = 2'h2;

   // -----------------------------------------------------------------
   // timing: 6.78 MHz base derived from 25 MHz by phase accumulation
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int BASE_HZ = 6_780_000;
   localparam int ACC_UNIT_HZ = 10_000;
   localparam logic [11:0] ACC_STEP = 12'(BASE_HZ / ACC_UNIT_HZ);
   localparam logic [11:0] ACC_MOD = 12'(CLK_HZ / ACC_UNIT_HZ);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } timer_state_t;

endpackage : cu_timer_pkg

// File: core/contactless_unit_timer.sv
// Operation
// - reload value is two byte registers, high and low, read/write, reset zero.
// - each start event loads counter with full 16-bit reload value.
// - reload byte writes leave running count alone until next start event; with auto-restart, reaching zero also loads them.
// - read-only register shows upper byte of live count; writes ignored.
// - read-only register shows lower byte of live count; writes ignored.
// - count rate is 6.78 MHz over 12-bit prescaler, nibble plus byte.
// - with auto-restart, reaching zero reloads and counting continues.
// - without auto-restart, counter stops at zero and sets timeout flag.
// - two-bit gating select: none, signal input, first auxiliary; 11 reserved.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
module contactless_unit_timer (
   input wire logic ref_clk_i,                             // 25 MHz clock
   input wire logic srst_i,                                // sync reset, high
   input wire logic ce_i,                                  // clock enable
   input wire logic signal_input_i,                        // gate source 01
   input wire logic first_auxiliary_signal_i,              // gate source 10
   input wire logic [cu_timer_pkg::ADDR_W-1:0] axi_awaddr_i, // write address
   input wire logic axi_awvalid_i,                         // write addr valid
   output logic axi_awready_o,                             // write addr ready
   input wire logic [cu_timer_pkg::DATA_W-1:0] axi_wdata_i, // write data
   input wire logic [3:0] axi_wstrb_i,                     // byte strobes
   input wire logic axi_wvalid_i,                          // write data valid
   output logic axi_wready_o,                              // write data ready
   output logic [1:0] axi_bresp_o,                         // write response
   output logic axi_bvalid_o,                              // write resp valid
   input wire logic axi_bready_i,                          // write resp ready
   input wire logic [cu_timer_pkg::ADDR_W-1:0] axi_araddr_i, // read address
   input wire logic axi_arvalid_i,                         // read addr valid
   output logic axi_arready_o,                             // read addr ready
   output logic [cu_timer_pkg::DATA_W-1:0] axi_rdata_o,    // read data
   output logic [1:0] axi_rresp_o,                         // read response
   output logic axi_rvalid_o,                              // read valid
   input wire logic axi_rready_i,                          // read ready
   output logic timer_running_o,                           // counter running
   output logic timeout_flag_o                             // sticky zero flag
);
   import cu_timer_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic [7:0] reload_value_upper_byte;
   logic [7:0] reload_value_lower_byte;
   logic [7:0] prescaler_lower_byte;
   logic [3:0] prescaler_upper_nibble;
   logic auto_reload_on_zero;
   logic [1:0] gating_source_select;
   logic [15:0] live_count;
   logic timeout_flag;
   timer_state_t state;
   logic [11:0] phase_acc;
   logic [11:0] presc_cnt;
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;

   // -----------------------------------------------------------------
   // write channel: address and data taken in either order
   // -----------------------------------------------------------------
   logic wr_fire;
   logic [15:0] wr_idx;
   logic wr_aligned;
   logic wr_mapped;
   logic wr_en;

   assign axi_awready_o = !aw_held && !axi_bvalid_o;
   assign axi_wready_o = !w_held && !axi_bvalid_o;
   assign wr_fire = aw_held && w_held && !axi_bvalid_o;
   assign wr_idx = 16'(aw_addr[ADDR_W-1:2]);
   assign wr_aligned = (aw_addr[1:0] == 2'h0);
   assign wr_en = wr_fire && wr_mapped && w_lane0;

   // decode of the held write address
   always_comb begin
      if (!wr_aligned) begin
         wr_mapped = 1'b0;
      end else if (wr_idx == IDX_PRESCALER_LOW || wr_idx == IDX_RELOAD_HIGH || wr_idx == IDX_RELOAD_LOW) begin
         wr_mapped = 1'b1;
      end else if (wr_idx == IDX_COUNT_HIGH || wr_idx == IDX_COUNT_LOW) begin
         wr_mapped = 1'b1;                    // accepted but no effect
      end else if (wr_idx == IDX_TIMER_MODE || wr_idx == IDX_TIMER_CTRL) begin
         wr_mapped = 1'b1;
      end else begin
         wr_mapped = 1'b0;
      end
   end

   // hold address and data until both have arrived
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_byte <= BYTE_RESET;
         w_lane0 <= 1'b0;
      end else if (ce_i) begin
         if (axi_awvalid_i && axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= axi_awaddr_i;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (axi_wvalid_i && axi_wready_o) begin
            w_held <= 1'b1;
            w_byte <= axi_wdata_i[7:0];
            w_lane0 <= axi_wstrb_i[0];
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // write response, one cycle after both halves are present
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         axi_bvalid_o <= 1'b0;
         axi_bresp_o <= RESP_OKAY;
      end else if (ce_i) begin
         if (wr_fire) begin
            axi_bvalid_o <= 1'b1;
            axi_bresp_o <= wr_mapped ? RESP_OKAY : RESP_DECERR;
         end else if (axi_bready_i) begin
            axi_bvalid_o <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------------
   logic start_evt;
   logic stop_evt;
   logic flag_clr;

   assign start_evt = wr_en && wr_idx == IDX_TIMER_CTRL && w_byte[CTRL_START_BIT];
   assign stop_evt = wr_en && wr_idx == IDX_TIMER_CTRL && w_byte[CTRL_STOP_BIT];
   assign flag_clr = wr_en && wr_idx == IDX_TIMER_CTRL && w_byte[CTRL_FLAG_BIT];

   // reload bytes feed the counter at a start event or at an auto reload on zero
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         reload_value_upper_byte <= BYTE_RESET;
         reload_value_lower_byte <= BYTE_RESET;
         prescaler_lower_byte <= BYTE_RESET;
         prescaler_upper_nibble <= BYTE_RESET[3:0];
         auto_reload_on_zero <= 1'b0;
         gating_source_select <= GATE_NONE;
      end else if (ce_i && wr_en) begin
         if (wr_idx == IDX_RELOAD_HIGH) begin
            reload_value_upper_byte <= w_byte;
         end else if (wr_idx == IDX_RELOAD_LOW) begin
            reload_value_lower_byte <= w_byte;
         end else if (wr_idx == IDX_PRESCALER_LOW) begin
            prescaler_lower_byte <= w_byte;
         end else if (wr_idx == IDX_TIMER_MODE) begin
            prescaler_upper_nibble <= w_byte[MODE_PRESC_LSB +: 4];
            auto_reload_on_zero <= w_byte[MODE_AUTO_BIT];
            gating_source_select <= w_byte[MODE_GATE_LSB +: 2];
         end
      end
   end

   // -----------------------------------------------------------------
   // tick generation: 6.78 MHz base, then gate, then prescaler
   // -----------------------------------------------------------------
   logic [11:0] reload_presc;
   logic [11:0] acc_sum;
   logic base_tick;
   logic gate_open;
   logic timer_tick;
   logic [15:0] reload_value;

   assign reload_value = {reload_value_upper_byte, reload_value_lower_byte};
   // a zero prescaler is taken as one so the timer never locks up
   assign reload_presc = ({prescaler_upper_nibble, prescaler_lower_byte} == 12'h000) ? PRESC_ONE
                         : {prescaler_upper_nibble, prescaler_lower_byte};
   assign acc_sum = phase_acc + ACC_STEP;
   assign base_tick = (acc_sum >= ACC_MOD);

   // reserved gate code keeps the timer held rather than guessing
   always_comb begin
      case (gating_source_select)
         GATE_NONE: gate_open = 1'b1;
         GATE_SIGNAL_INPUT: gate_open = signal_input_i;
         GATE_FIRST_AUX: gate_open = first_auxiliary_signal_i;
         default: gate_open = 1'b0;
      endcase
   end

   assign timer_tick = (state == ST_RUN) && base_tick && gate_open && (presc_cnt + PRESC_ONE >= reload_presc);

   // free-running phase accumulator, average rate 678/2500 of the clock
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         phase_acc <= 12'h000;
      end else if (ce_i) begin
         phase_acc <= base_tick ? acc_sum - ACC_MOD : acc_sum;
      end
   end

   // prescaler restarts with every start event so the first period is whole
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         presc_cnt <= 12'h000;
      end else if (ce_i) begin
         if (start_evt || timer_tick) begin
            presc_cnt <= 12'h000;
         end else if (state == ST_RUN && base_tick && gate_open) begin
            presc_cnt <= presc_cnt + PRESC_ONE;
         end
      end
   end

   // -----------------------------------------------------------------
   // counter and run state
   // -----------------------------------------------------------------
   logic zero_reached;

   assign zero_reached = timer_tick && (live_count == COUNT_ONE || live_count == COUNT_RESET);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state <= ST_IDLE;
         live_count <= COUNT_RESET;
      end else if (ce_i) begin
         case (state)
            ST_IDLE: begin
               if (start_evt) begin
                  live_count <= reload_value;
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (start_evt) begin
                  live_count <= reload_value;
               end else if (stop_evt) begin
                  state <= ST_IDLE;
               end else if (timer_tick) begin
                  if (live_count == COUNT_RESET) begin
                     // only reached here with auto reload or a zero reload value
                     if (auto_reload_on_zero) begin
                        live_count <= reload_value;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end else begin
                     live_count <= live_count - COUNT_ONE;
                     if (live_count == COUNT_ONE && !auto_reload_on_zero) begin
                        state <= ST_IDLE;
                     end
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // sticky flag: a new zero in the clear cycle wins over the clear
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         timeout_flag <= 1'b0;
      end else if (ce_i) begin
         if (zero_reached && !start_evt && !stop_evt) begin
            timeout_flag <= 1'b1;
         end else if (flag_clr) begin
            timeout_flag <= 1'b0;
         end
      end
   end

   assign timer_running_o = (state == ST_RUN);
   assign timeout_flag_o = timeout_flag;

   // -----------------------------------------------------------------
   // read channel: one read at a time, data registered
   // -----------------------------------------------------------------
   logic [15:0] rd_idx;
   logic [7:0] rd_byte;
   logic rd_mapped;

   assign axi_arready_o = !axi_rvalid_o;
   assign rd_idx = 16'(axi_araddr_i[ADDR_W-1:2]);

   // read mux; live count bytes follow the counter every cycle
   always_comb begin
      rd_byte = BYTE_RESET;
      rd_mapped = 1'b1;
      if (axi_araddr_i[1:0] != 2'h0) begin
         rd_mapped = 1'b0;
      end else if (rd_idx == IDX_RELOAD_HIGH) begin
         rd_byte = reload_value_upper_byte;
      end else if (rd_idx == IDX_RELOAD_LOW) begin
         rd_byte = reload_value_lower_byte;
      end else if (rd_idx == IDX_COUNT_HIGH) begin
         rd_byte = live_count[15:8];
      end else if (rd_idx == IDX_COUNT_LOW) begin
         rd_byte = live_count[7:0];
      end else if (rd_idx == IDX_PRESCALER_LOW) begin
         rd_byte = prescaler_lower_byte;
      end else if (rd_idx == IDX_TIMER_MODE) begin
         rd_byte = {1'b0, gating_source_select, auto_reload_on_zero, prescaler_upper_nibble};
      end else if (rd_idx == IDX_TIMER_CTRL) begin
         rd_byte = {4'h0, timeout_flag, timer_running_o, 2'h0};
      end else begin
         rd_mapped = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         axi_rvalid_o <= 1'b0;
         axi_rdata_o <= '0;
         axi_rresp_o <= RESP_OKAY;
      end else if (ce_i) begin
         if (axi_arvalid_i && axi_arready_o) begin
            axi_rvalid_o <= 1'b1;
            axi_rdata_o <= {24'h000000, rd_byte};
            axi_rresp_o <= rd_mapped ? RESP_OKAY : RESP_DECERR;
         end else if (axi_rready_i) begin
            axi_rvalid_o <= 1'b0;
         end
      end
   end

endmodule : contactless_unit_timer

// File: bench/cu_timer_monitor.sv
`timescale 1ns/100ps
module cu_timer_monitor (
   input wire logic ref_clk_i, // clock
   input wire logic srst_i, // reset
   input wire logic axi_awvalid_i, // aw valid
   input wire logic axi_awready_o, // aw ready
   input wire logic axi_wvalid_i, // w valid
   input wire logic axi_wready_o, // w ready
   input wire logic [1:0] axi_bresp_o, // b resp
   input wire logic axi_bvalid_o, // b valid
   input wire logic axi_bready_i, // b ready
   input wire logic axi_arready_o, // ar ready
   input wire logic [cu_timer_pkg::DATA_W-1:0] axi_rdata_o, // r data
   input wire logic axi_rvalid_o, // r valid
   input wire logic axi_rready_i, // r ready
   input wire logic timer_running_o, // running
   input wire logic timeout_flag_o // sticky flag
);
   import cu_timer_pkg::*;
   // ---------------------------------------------------------------
   // bus and timer checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   // a write whose halves meet on one edge is answered two edges later at most
   sequence s_wr_taken; axi_awvalid_i && axi_awready_o && axi_wvalid_i && axi_wready_o; endsequence
   sequence s_wr_answer; ##[1:2] axi_bvalid_o; endsequence
   property p_wr_answer; s_wr_taken |-> s_wr_answer; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
   property p_b_stand; axi_bvalid_o && !axi_bready_i |=> axi_bvalid_o && $stable(axi_bresp_o); endproperty
   a_b_stand: assert property (p_b_stand) else $error("write response dropped");
   property p_r_stand; axi_rvalid_o && !axi_rready_i |=> axi_rvalid_o && $stable(axi_rdata_o); endproperty
   a_r_stand: assert property (p_r_stand) else $error("read data dropped");
   property p_refuse; (axi_bvalid_o |-> !axi_awready_o) and (axi_rvalid_o |-> !axi_arready_o); endproperty
   a_refuse: assert property (p_refuse) else $error("request taken while busy");
   property p_byte_data; axi_rvalid_o |-> axi_rdata_o[DATA_W-1:8] == '0; endproperty
   a_byte_data: assert property (p_byte_data) else $error("upper read bits set");
   // running only starts at the edge a write takes effect
   property p_start; $rose(timer_running_o) |-> $rose(axi_bvalid_o); endproperty
   a_start: assert property (p_start) else $error("start without write");
   property p_zero_stop; $fell(timer_running_o) && !$rose(axi_bvalid_o) |-> timeout_flag_o; endproperty
   a_zero_stop: assert property (p_zero_stop) else $error("stop without flag");
   property p_reset; disable iff (1'h0) srst_i |=> !timer_running_o && !timeout_flag_o && !axi_bvalid_o; endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : cu_timer_monitor

bind contactless_unit_timer cu_timer_monitor mon (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
   .axi_awvalid_i(axi_awvalid_i), .axi_awready_o(axi_awready_o), .axi_wvalid_i(axi_wvalid_i),
   .axi_wready_o(axi_wready_o), .axi_bresp_o(axi_bresp_o), .axi_bvalid_o(axi_bvalid_o),
   .axi_bready_i(axi_bready_i), .axi_arready_o(axi_arready_o), .axi_rdata_o(axi_rdata_o),
   .axi_rvalid_o(axi_rvalid_o), .axi_rready_i(axi_rready_i), .timer_running_o(timer_running_o),
   .timeout_flag_o(timeout_flag_o));

// File: bench/contactless_unit_timer_tb_top.sv
`timescale 1ns/100ps
module contactless_unit_timer_tb_top;
   import cu_timer_pkg::*;
   logic clk = 1'h0, srst = 1'h1, sig_in = 1'h0, aux_in = 1'h0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, running, flag;
   logic [1:0] bresp, rresp;
   int err_count = 0, n_checks = 0;
   always #20 clk = ~clk;
   contactless_unit_timer DUT (.ref_clk_i(clk), .srst_i(srst), .ce_i(1'h1), .signal_input_i(sig_in),
      .first_auxiliary_signal_i(aux_in), .axi_awaddr_i(awaddr), .axi_awvalid_i(awvalid),
      .axi_awready_o(awready), .axi_wdata_i(wdata), .axi_wstrb_i(4'hF), .axi_wvalid_i(wvalid),
      .axi_wready_o(wready), .axi_bresp_o(bresp), .axi_bvalid_o(bvalid), .axi_bready_i(bready),
      .axi_araddr_i(araddr), .axi_arvalid_i(arvalid), .axi_arready_o(arready), .axi_rdata_o(rdata),
      .axi_rresp_o(rresp), .axi_rvalid_o(rvalid), .axi_rready_i(rready), .timer_running_o(running),
      .timeout_flag_o(flag));
   // ---------------------------------------------------------------
   // bus tasks; ready is judged at the falling edge so the release lands on the taking edge
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic aw_ok, w_ok, b_ok, seen;
      logic [1:0] r;
      @(posedge clk);
      awaddr <= ADDR_W'({idx, 2'h0});
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      do begin
         @(negedge clk);
         aw_ok = awvalid & awready;
         w_ok = wvalid & wready;
         b_ok = bvalid & bready;
         seen = bvalid;
         r = bresp;
         @(posedge clk);
         if (aw_ok) awvalid <= 1'h0;
         if (w_ok) wvalid <= 1'h0;
         bready <= seen & ~b_ok; // late ready lets the response stand a cycle
      end while (!b_ok);
      chk({30'h0, r}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic ar_ok, r_ok, seen;
      @(posedge clk);
      araddr <= ADDR_W'({idx, 2'h0});
      arvalid <= 1'h1;
      do begin
         @(negedge clk);
         ar_ok = arvalid & arready;
         r_ok = rvalid & rready;
         seen = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar_ok) arvalid <= 1'h0;
         rready <= seen & ~r_ok;
      end while (!r_ok);
   endtask : rd
   task automatic rchk(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(idx, d, r);
      chk(d, exp);
      chk({30'h0, r}, {30'h0, er});
   endtask : rchk
   task automatic rcnt(output logic [15:0] c);
      logic [31:0] h, l;
      logic [1:0] r;
      rd(IDX_COUNT_HIGH, h, r);
      rd(IDX_COUNT_LOW, l, r);
      c = {h[7:0], l[7:0]};
   endtask : rcnt
   // status pins are looked at mid-cycle, away from the edge that updates them
   task automatic chk_out(input logic r_exp, input logic f_exp);
      @(negedge clk);
      chk({31'h0, running}, {31'h0, r_exp});
      chk({31'h0, flag}, {31'h0, f_exp});
   endtask : chk_out
   task automatic start(input logic [11:0] p, input logic [7:0] m, input logic [15:0] rl);
      wr(IDX_PRESCALER_LOW, p[7:0], RESP_OKAY);
      wr(IDX_TIMER_MODE, m | {4'h0, p[11:8]}, RESP_OKAY);
      wr(IDX_RELOAD_HIGH, rl[15:8], RESP_OKAY);
      wr(IDX_RELOAD_LOW, rl[7:0], RESP_OKAY);
      wr(IDX_TIMER_CTRL, 8'h01, RESP_OKAY);
   endtask : start
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      logic [15:0] ix [6] = '{IDX_RELOAD_HIGH, IDX_RELOAD_LOW, IDX_COUNT_HIGH, IDX_COUNT_LOW,
         IDX_PRESCALER_LOW, IDX_TIMER_MODE};
      foreach (ix[i]) rchk(ix[i], 32'h0, RESP_OKAY);
      wr(IDX_RELOAD_HIGH, 8'hA5, RESP_OKAY);
      wr(IDX_RELOAD_LOW, 8'h3C, RESP_OKAY);
      wr(IDX_COUNT_HIGH, 8'hFF, RESP_OKAY);
      wr(IDX_COUNT_LOW, 8'hFF, RESP_OKAY);
      rchk(IDX_RELOAD_HIGH, 32'hA5, RESP_OKAY);
      rchk(IDX_RELOAD_LOW, 32'h3C, RESP_OKAY);
      rchk(IDX_COUNT_HIGH, 32'h0, RESP_OKAY);
      rchk(IDX_COUNT_LOW, 32'h0, RESP_OKAY);
      wr(16'h6320, 8'h11, RESP_DECERR);
      rchk(16'h6320, 32'h0, RESP_DECERR);
   endtask : t_regs
   // one-shot run timed from start to stop; jitter of the base tick allows a few cycles
   task automatic t_rate(input logic [11:0] p, input logic [15:0] rl);
      int n, e;
      logic [15:0] c;
      e = int'(rl) * ((p == 12'h0) ? 1 : int'(p)) * (CLK_HZ / 10000) / (BASE_HZ / 10000);
      n = 0;
      start(p, 8'h00, rl);
      do begin
         @(negedge clk);
         n++;
      end while (running === 1'h1 && n < 5000);
      chk({31'h0, n > e - 8 && n < e + 8}, 32'h1);
      chk_out(1'h0, 1'h1);
      rcnt(c);
      chk({16'h0, c}, 32'h0);
      wr(IDX_TIMER_CTRL, 8'h08, RESP_OKAY);
      chk_out(1'h0, 1'h0);
   endtask : t_rate
   task automatic t_reload();
      logic [15:0] c, c2;
      start(12'h010, 8'h00, 16'h0040);
      wr(IDX_RELOAD_HIGH, 8'h12, RESP_OKAY);
      wr(IDX_RELOAD_LOW, 8'h34, RESP_OKAY);
      rcnt(c);
      chk({31'h0, c <= 16'h0040 && c > 16'h0030}, 32'h1);
      wr(IDX_TIMER_CTRL, 8'h02, RESP_OKAY);
      chk_out(1'h0, 1'h0);
      rcnt(c);
      repeat (100) @(posedge clk);
      rcnt(c2);
      chk({16'h0, c2}, {16'h0, c});
      wr(IDX_TIMER_CTRL, 8'h01, RESP_OKAY);
      rcnt(c);
      chk({31'h0, c <= 16'h1234 && c > 16'h1220}, 32'h1);
      wr(IDX_TIMER_CTRL, 8'h02, RESP_OKAY);
   endtask : t_reload
   task automatic t_auto();
      logic [15:0] c;
      start(12'h000, 8'h10, 16'h0003);
      repeat (200) @(posedge clk);
      chk_out(1'h1, 1'h1);
      rcnt(c);
      chk({31'h0, c <= 16'h0003}, 32'h1);
      wr(IDX_TIMER_CTRL, 8'h0A, RESP_OKAY);
   endtask : t_auto
   // closed gate: only the wrong source is high, none for code 11; open: selected source high, both for 11, which stays held
   task automatic t_gate();
      logic [15:0] c;
      for (int g = 1; g < 4; g++) begin
         sig_in <= (g == 2);
         aux_in <= (g == 1);
         start(12'h000, 8'(g << 5), 16'h0005);
         repeat (100) @(posedge clk);
         rcnt(c);
         chk({16'h0, c}, 32'h5);
         sig_in <= (g != 2);
         aux_in <= (g != 1);
         repeat (100) @(posedge clk);
         chk_out(g == 3, g != 3);
         wr(IDX_TIMER_CTRL, 8'h0A, RESP_OKAY);
      end
   endtask : t_gate
   task automatic summarize();
      if (err_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   // main sequence after a 16-cycle reset
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'h0;
      t_regs();
      t_rate(12'h010, 16'h0004);
      t_rate(12'h100, 16'h0002);
      t_rate(12'h000, 16'h0010);
      t_reload();
      t_auto();
      t_gate();
      summarize();
   end
   // watchdog well beyond the expected run of under 8000 cycles
   initial begin
      #(40 * 40000);
      err_count++;
      summarize();
   end
endmodule : contactless_unit_timer_tb_top
